// *** rtl/dcisp_slave.sv ***
// Device end: dual card I2C slave port with supervisor
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "dcisp_defs.svh"
module dcisp_slave
	import dcisp_pkg::*;
#(
	parameter logic [15:0] SUP_DELAY = `DCISP_SUP_DELAY
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Straps and supervisor
	input wire logic addrStrapLow,
	input wire logic addrStrapHigh,
	input wire logic supplyOk,
	// Card status sources, per card
	input wire logic [1:0] cardPresent,
	input wire logic [1:0] cardIoLevel,
	input wire logic [1:0] cardActive,
	input wire logic [1:0] muteEvent,
	input wire logic [1:0] earlyEvent,
	input wire logic [1:0] protEvent,
	// Card control outputs
	output logic [7:0] card0Ctrl,
	output logic [7:0] card1Ctrl,
	output logic [1:0] ctrlStrobe,
	output logic emergencyDeact,
	// I2C bus
	dcisp_bus_if.device bus
);
	dcisp_sst_t st_r;
	logic sclS1_r, sclS2_r, sclD_r, sdaS1_r, sdaS2_r, sdaD_r;
	logic strH1_r, strH2_r, strL1_r, strL2_r, supS1_r, supS2_r;
	logic [7:0] shift_r, ctrl0_r, ctrl1_r;
	logic [3:0] bitCnt_r;
	logic card_r, read_r, sdaOe_r, irqOe_r, deact_r;
	logic [1:0] strobe_r, presD_r, presChg_r, mute_r, early_r, overload_protection_flag_r, supFlt_r;
	logic [15:0] supCnt_r;
	logic [1:0] strap_r;
	// Bus condition decode
	wire sclRise = sclS2_r & ~sclD_r;
	wire sclFall = ~sclS2_r & sclD_r;
	wire startCond = sclS2_r & sclD_r & ~sdaS2_r & sdaD_r;
	wire stopCond = sclS2_r & sclD_r & sdaS2_r & ~sdaD_r;
	wire supActive = (supCnt_r != SUP_DELAY);
	wire [7:0] addrByte = {shift_r[6:0], sdaS2_r};
	wire addrHit = (addrByte[7:4] == `DCISP_ADDR_BASE) && (addrByte[2:1] == strap_r);
	wire addrCard = addrByte[`DCISP_ADDR_CARD_BIT];
	wire [7:0] status0 = statusByte(1'b0);
	wire [7:0] status1 = statusByte(1'b1);
	wire [7:0] curStatus = card_r ? status1 : status0;
	wire statusRead = (st_r == DCISP_S_AACK) & sclFall & read_r;
	wire [1:0] rdClr = {statusRead & card_r, statusRead & ~card_r};
	wire [1:0] presNow = {strL2_r, strL2_r} & 2'b00 | cardPresent;
	wire anyEvent = |{presChg_r, mute_r, early_r, overload_protection_flag_r};
	// Status byte of one card
	function automatic logic [7:0] statusByte(input logic c);
		statusByte = {cardActive[c], early_r[c], mute_r[c], overload_protection_flag_r[c], supFlt_r[c],
			cardIoLevel[c], presChg_r[c], cardPresent[c]};
	endfunction
	// Synchronisers and edge history
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{sclS1_r, sclS2_r, sclD_r, sdaS1_r, sdaS2_r, sdaD_r} <= 6'h3F;
			{strH1_r, strH2_r, strL1_r, strL2_r, supS1_r, supS2_r} <= 6'h00;
		end else begin
			{sclS1_r, sdaS1_r, strH1_r, strL1_r, supS1_r} <= {bus.scl, bus.sda, addrStrapHigh, addrStrapLow, supplyOk};
			{sclS2_r, sdaS2_r, strH2_r, strL2_r, supS2_r} <= {sclS1_r, sdaS1_r, strH1_r, strL1_r, supS1_r};
			{sclD_r, sdaD_r} <= {sclS2_r, sdaS2_r};
		end
	end
	// Supervisor: delay count, strap capture, emergency deactivation
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			supCnt_r <= 16'h0;
			strap_r <= 2'h0;
			deact_r <= 1'b1;
		end else begin
			if (!supS2_r)
				supCnt_r <= 16'h0;
			else if (supActive)
				supCnt_r <= supCnt_r + 16'h0001;
			if (supActive)
				strap_r <= {strH2_r, strL2_r};
			deact_r <= supActive;
		end
	end
	// Sticky flags, set wins over read clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{presD_r, presChg_r, mute_r, early_r, overload_protection_flag_r} <= 10'h0;
			supFlt_r <= 2'b11;
		end else begin
			presD_r <= presNow;
			presChg_r <= (presNow ^ presD_r) | (presChg_r & ~rdClr);
			mute_r <= muteEvent | (mute_r & ~rdClr);
			early_r <= earlyEvent | (early_r & ~rdClr);
			overload_protection_flag_r <= protEvent | (overload_protection_flag_r & ~rdClr);
			supFlt_r <= {supActive, supActive} | (supFlt_r & ~rdClr);
		end
	end
	// Slave byte engine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= DCISP_S_IDLE;
			shift_r <= 8'h0;
			bitCnt_r <= 4'h0;
			{card_r, read_r} <= 2'b00;
			sdaOe_r <= 1'b1;
			ctrl0_r <= `DCISP_CTRL_RESET;
			ctrl1_r <= `DCISP_CTRL_RESET;
			strobe_r <= 2'b00;
		end else begin
			strobe_r <= 2'b00;
			if (supActive) begin
				ctrl0_r <= `DCISP_CTRL_RESET;
				ctrl1_r <= `DCISP_CTRL_RESET;
			end
			if (startCond) begin
				st_r <= DCISP_S_ADDR;
				bitCnt_r <= 4'h0;
				sdaOe_r <= 1'b1;
			end else if (stopCond) begin
				st_r <= DCISP_S_IDLE;
				sdaOe_r <= 1'b1;
			end else begin
				case (st_r)
					DCISP_S_IDLE: sdaOe_r <= 1'b1;
					DCISP_S_ADDR, DCISP_S_WDAT: begin
						if (sclRise) begin
							shift_r <= addrByte;
							bitCnt_r <= bitCnt_r + 4'h1;
						end
						if (sclFall && bitCnt_r == 4'h8) begin
							bitCnt_r <= 4'h0;
							if (st_r == DCISP_S_WDAT) begin
								sdaOe_r <= 1'b0;
								if (card_r) begin
									ctrl1_r <= shift_r;
								end else begin
									ctrl0_r <= shift_r;
								end
								strobe_r <= {card_r, ~card_r};
								st_r <= DCISP_S_AACK;
							end else if (shift_r[7:4] == `DCISP_ADDR_BASE && shift_r[2:1] == strap_r) begin
								card_r <= shift_r[`DCISP_ADDR_CARD_BIT];
								read_r <= shift_r[`DCISP_ADDR_RW_BIT];
								sdaOe_r <= 1'b0;
								st_r <= DCISP_S_AACK;
							end else
								st_r <= DCISP_S_IDLE;
						end
					end
					DCISP_S_AACK: if (sclFall) begin
						if (read_r) begin
							shift_r <= {curStatus[6:0], 1'b1};
							sdaOe_r <= curStatus[7];
							st_r <= DCISP_S_RDAT;
						end else begin
							sdaOe_r <= 1'b1;
							st_r <= DCISP_S_WDAT;
						end
					end
					DCISP_S_RDAT: if (sclFall) begin
						bitCnt_r <= bitCnt_r + 4'h1;
						if (bitCnt_r == 4'h7) begin
							sdaOe_r <= 1'b1;
							bitCnt_r <= 4'h0;
							st_r <= DCISP_S_RACK;
						end else begin
							sdaOe_r <= shift_r[7];
							shift_r <= {shift_r[6:0], 1'b1};
						end
					end
					DCISP_S_RACK: if (sclRise) begin
						if (sdaS2_r)
							st_r <= DCISP_S_IDLE;
						else
							st_r <= DCISP_S_AACK;
					end
					default: st_r <= DCISP_S_IDLE;
				endcase
			end
		end
	end
	// Interrupt: open drain, low while supervisor or events
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			irqOe_r <= 1'b0;
		else
			irqOe_r <= ~(supActive | anyEvent);
	end
	// Open-drain drive only pulls low
	assign bus.sdaSlaveOe_n = sdaOe_r;
	assign bus.sclSlaveOe_n = 1'b1;
	assign bus.irqSlaveOe_n = irqOe_r;
	assign card0Ctrl = ctrl0_r;
	assign card1Ctrl = ctrl1_r;
	assign ctrlStrobe = strobe_r;
	assign emergencyDeact = deact_r;
endmodule

// *** rtl/dcisp_defs.svh ***
// Constants of the dual card I2C slave port
`ifndef DCISP_DEFS_SVH
`define DCISP_DEFS_SVH
// Address byte layout
`define DCISP_ADDR_BASE 4'h4
`define DCISP_ADDR_CARD_BIT 3
`define DCISP_ADDR_BIT_ONE 2
`define DCISP_ADDR_BIT_ZERO 1
`define DCISP_ADDR_RW_BIT 0
// Status byte fields
`define DCISP_ST_PRES 0
`define DCISP_ST_PRESCHG 1
`define DCISP_ST_IOLVL 2
`define DCISP_ST_SUPFAULT 3
`define DCISP_ST_OVERLOAD_PROTECTION_FLAG 4
`define DCISP_ST_MUTE 5
`define DCISP_ST_EARLY 6
`define DCISP_ST_ACTIVE 7
// Reset values
`define DCISP_CTRL_RESET 8'h00
// Timing: master divider, SCL period 10 us at 100 kHz
`define DCISP_SCL_KHZ 100
`define DCISP_CLK_KHZ 10000
`define DCISP_QUARTER_CYC ((`DCISP_CLK_KHZ / `DCISP_SCL_KHZ) / 4)
// Supervisor delay in cycles
`define DCISP_SUP_DELAY 16'h0100
`endif

// *** rtl/dcisp_pkg.sv ***
// Types of the dual card I2C slave port
package dcisp_pkg;
	typedef enum logic [5:0] {
		DCISP_S_IDLE = 6'h01,
		DCISP_S_ADDR = 6'h02,
		DCISP_S_AACK = 6'h04,
		DCISP_S_WDAT = 6'h08,
		DCISP_S_RDAT = 6'h10,
		DCISP_S_RACK = 6'h20
	} dcisp_sst_t;
	typedef enum logic [6:0] {
		DCISP_M_IDLE = 7'h01,
		DCISP_M_START = 7'h02,
		DCISP_M_BIT = 7'h04,
		DCISP_M_ACK = 7'h08,
		DCISP_M_STOP = 7'h10,
		DCISP_M_DONE = 7'h20,
		DCISP_M_WAIT = 7'h40
	} dcisp_mst_t;
endpackage

// *** rtl/dcisp_bus_if.sv ***
// Open-drain I2C wires joining master and slave port
`timescale 1ns/1ns
interface dcisp_bus_if;
	logic sclMasterOe_n;
	logic sdaMasterOe_n;
	logic sclSlaveOe_n;
	logic sdaSlaveOe_n;
	logic irqSlaveOe_n;
	logic sclOut;
	logic sdaOut;
	logic irqOut;
	logic scl;
	logic sda;
	logic irq_n;
	// Wired-AND with pull-ups
	assign scl = ~((~sclMasterOe_n & ~sclOut) | (~sclSlaveOe_n & ~sclOut));
	assign sda = ~(~sdaMasterOe_n | ~sdaSlaveOe_n);
	assign irq_n = irqSlaveOe_n;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign irqOut = 1'b0;
	modport device (input scl, input sda, output sclSlaveOe_n, output sdaSlaveOe_n, output irqSlaveOe_n);
	modport host (input scl, input sda, input irq_n, output sclMasterOe_n, output sdaMasterOe_n);
endinterface

// *** rtl/dcisp_master.sv ***
// Host end: Avalon-MM controlled I2C master
`timescale 1ns/1ns
`include "dcisp_defs.svh"
module dcisp_master
	import dcisp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	// I2C bus
	dcisp_bus_if.host bus
);
	// Registers: 0 command (addr byte [7:0], data [15:8], go [16]), 1 status
	localparam logic [1:0] RegCmd = 2'h0;
	localparam logic [1:0] RegStat = 2'h1;
	localparam logic [15:0] Quarter = 16'(`DCISP_QUARTER_CYC);
	dcisp_mst_t st_r;
	logic [7:0] addr_r, wdat_r, rdat_r, shift_r;
	logic [15:0] tick_r;
	logic [1:0] ph_r;
	logic [3:0] bitCnt_r;
	logic busy_r, nack_r, second_r, sclOe_r, sdaOe_r;
	logic [31:0] rdata_r;
	logic wait_r;
	logic sclS1_r, sclS2_r, sdaS1_r, sdaS2_r, irqS1_r, irqS2_r;
	// Bus decode
	wire access = (avsRead | avsWrite) & wait_r;
	wire goCmd = avsWrite & wait_r & (avsAddress == RegCmd) & avsWritedata[16] & ~busy_r;
	wire tickEnd = (tick_r == Quarter - 16'h0001);
	wire isRead = addr_r[`DCISP_ADDR_RW_BIT];
	wire [31:0] statWord = {26'h0, ~irqS2_r, sdaS2_r, sclS2_r, nack_r, busy_r, 1'b0} | {16'h0, rdat_r, 8'h00};
	// Avalon slave, one wait cycle per access
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
		end else begin
			wait_r <= ~access;
			if (access & avsRead)
				rdata_r <= (avsAddress == RegStat) ? statWord : {16'h0, wdat_r, addr_r};
		end
	end
	assign avsReaddata = rdata_r;
	assign avsWaitrequest = wait_r | ~(avsRead | avsWrite) ? 1'b1 : 1'b0;
	// Pin synchronisers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{sclS1_r, sclS2_r, sdaS1_r, sdaS2_r, irqS1_r, irqS2_r} <= 6'h3F;
		end else begin
			{sclS1_r, sdaS1_r, irqS1_r} <= {bus.scl, bus.sda, bus.irq_n};
			{sclS2_r, sdaS2_r, irqS2_r} <= {sclS1_r, sdaS1_r, irqS1_r};
		end
	end
	// Bit engine: four quarter phases per SCL period
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= DCISP_M_IDLE;
			tick_r <= 16'h0;
			ph_r <= 2'h0;
			bitCnt_r <= 4'h0;
			{addr_r, wdat_r, rdat_r, shift_r} <= 32'h0;
			{busy_r, nack_r, second_r} <= 3'h0;
			sclOe_r <= 1'b1;
			sdaOe_r <= 1'b1;
		end else begin
			tick_r <= (st_r == DCISP_M_IDLE || tickEnd) ? 16'h0 : tick_r + 16'h0001;
			if (tickEnd)
				ph_r <= ph_r + 2'h1;
			case (st_r)
				DCISP_M_IDLE: begin
					ph_r <= 2'h0;
					if (goCmd) begin
						addr_r <= avsWritedata[7:0];
						wdat_r <= avsWritedata[15:8];
						shift_r <= avsWritedata[7:0];
						{busy_r, nack_r, second_r} <= 3'b100;
						st_r <= DCISP_M_WAIT;
					end
				end
				DCISP_M_WAIT: begin
					if (sclS2_r & sdaS2_r)
						st_r <= DCISP_M_START;
				end
				DCISP_M_START: begin
					if (tickEnd && ph_r == 2'h1)
						sdaOe_r <= 1'b0;
					if (tickEnd && ph_r == 2'h3) begin
						sclOe_r <= 1'b0;
						bitCnt_r <= 4'h0;
						st_r <= DCISP_M_BIT;
					end
				end
				DCISP_M_BIT: if (tickEnd) begin
					case (ph_r)
						2'h0: sdaOe_r <= (second_r & isRead) ? 1'b1 : shift_r[7];
						2'h1: sclOe_r <= 1'b1;
						2'h2: shift_r <= {shift_r[6:0], sdaS2_r};
						default: begin
							sclOe_r <= 1'b0;
							if (bitCnt_r == 4'h7)
								st_r <= DCISP_M_ACK;
							bitCnt_r <= bitCnt_r + 4'h1;
						end
					endcase
				end
				DCISP_M_ACK: if (tickEnd) begin
					case (ph_r)
						2'h0: sdaOe_r <= ~(second_r & isRead) ? 1'b1 : 1'b1;
						2'h1: sclOe_r <= 1'b1;
						2'h2: begin
							if (second_r & isRead)
								rdat_r <= shift_r;
							else
								nack_r <= nack_r | sdaS2_r;
						end
						default: begin
							sclOe_r <= 1'b0;
							bitCnt_r <= 4'h0;
							if (!second_r && !sdaS2_r) begin
								second_r <= 1'b1;
								shift_r <= isRead ? 8'hFF : wdat_r;
								st_r <= DCISP_M_BIT;
							end else
								st_r <= DCISP_M_STOP;
						end
					endcase
				end
				DCISP_M_STOP: if (tickEnd) begin
					case (ph_r)
						2'h0: sdaOe_r <= 1'b0;
						2'h1: sclOe_r <= 1'b1;
						2'h2: sdaOe_r <= 1'b1;
						default: st_r <= DCISP_M_DONE;
					endcase
				end
				DCISP_M_DONE: begin
					busy_r <= 1'b0;
					st_r <= DCISP_M_IDLE;
				end
				default: st_r <= DCISP_M_IDLE;
			endcase
		end
	end
	assign bus.sclMasterOe_n = sclOe_r;
	assign bus.sdaMasterOe_n = sdaOe_r;
endmodule

// *** dv/dcisp_chk.sv ***
// Checker of the open-drain bus between host end and device end
`timescale 1ns/1ns
module dcisp_chk #(
	parameter logic [1:0] STRAPS = 2'h0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Resolved wires and drive levels
	input wire logic scl,
	input wire logic sda,
	input wire logic sclOut,
	input wire logic sdaOut,
	input wire logic irqOut,
	// Device enables
	input wire logic sdaSlaveOe_n
);
	logic sclD_r;
	logic sdaD_r;
	logic nack_r;
	logic [4:0] bitCnt_r;
	logic [7:0] addrSh_r;
	// ==========================================
	// Bus event decoding
	wire startEv = sclD_r & scl & sdaD_r & ~sda;
	wire stopEv = sclD_r & scl & ~sdaD_r & sda;
	wire sclRise = ~sclD_r & scl;
	wire addrHit = (addrSh_r[7:4] == 4'h4) && (addrSh_r[2:1] == STRAPS);
	wire nackEv = sclRise & (bitCnt_r == 5'h11) & addrHit & addrSh_r[0] & sda;
	// Clock count since START, address shift, read end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
			nack_r <= 1'b0;
			bitCnt_r <= 5'h1F;
			addrSh_r <= 8'h00;
		end else begin
			sclD_r <= scl;
			sdaD_r <= sda;
			if (startEv) bitCnt_r <= 5'h00;
			else if (stopEv) bitCnt_r <= 5'h1F;
			else if (sclRise && bitCnt_r != 5'h1F) bitCnt_r <= bitCnt_r + 5'h01;
			if (sclRise && bitCnt_r < 5'h08) addrSh_r <= {addrSh_r[6:0], sda};
			nack_r <= (nack_r | nackEv) & ~startEv & ~stopEv;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_start;
		startEv;
	endsequence
	sequence s_addr_ack_clk;
		sclRise && bitCnt_r == 5'h08;
	endsequence
	sequence s_data_ack_clk;
		sclRise && bitCnt_r == 5'h11 && addrHit && !addrSh_r[0];
	endsequence
	property p_open_drain;
		!sclOut && !sdaOut && !irqOut;
	endproperty
	property p_hold_high;
		sclD_r && scl |-> $stable(sdaSlaveOe_n);
	endproperty
	property p_start_master;
		s_start |-> $past(sdaSlaveOe_n);
	endproperty
	property p_addr_release;
		bitCnt_r < 5'h08 |-> sdaSlaveOe_n;
	endproperty
	property p_addr_ack;
		s_addr_ack_clk |-> sdaSlaveOe_n == !addrHit;
	endproperty
	property p_data_ack;
		s_data_ack_clk |-> !sdaSlaveOe_n [*8];
	endproperty
	property p_nack_release;
		nack_r |-> sdaSlaveOe_n;
	endproperty
	property p_stop_release;
		stopEv |=> sdaSlaveOe_n [*3];
	endproperty
	property p_frame_len;
		stopEv |-> bitCnt_r == 5'h13 || bitCnt_r == 5'h0A;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("bus driven high");
	a_hold_high: assert property (p_hold_high)
		else $error("device changed data while clock high");
	a_start_master: assert property (p_start_master)
		else $error("start while device held data low");
	a_addr_release: assert property (p_addr_release)
		else $error("device drove data during address byte");
	a_addr_ack: assert property (p_addr_ack)
		else $error("address acknowledge wrong");
	a_data_ack: assert property (p_data_ack)
		else $error("control byte not acknowledged");
	a_nack_release: assert property (p_nack_release)
		else $error("data not released after read end");
	a_stop_release: assert property (p_stop_release)
		else $error("data not released after stop");
	a_frame_len: assert property (p_frame_len)
		else $error("frame length wrong");
endmodule

// *** dv/testbench.sv ***
// Self-checking bench joining host end and device end
`timescale 1ns/1ns
module testbench
	import dcisp_pkg::*;
;
	localparam logic [1:0] CMD_ADDR = 2'h0;
	localparam logic [1:0] STAT_ADDR = 2'h1;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] avsAddress = 2'h0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic supplyOk = 1'b1;
	logic [1:0] cardPresent = 2'h1;
	logic [1:0] cardIoLevel = 2'h0;
	logic [1:0] cardActive = 2'h0;
	logic [1:0] muteEvent = 2'h0;
	logic [1:0] earlyEvent = 2'h0;
	logic [1:0] protEvent = 2'h0;
	logic [7:0] card0Ctrl;
	logic [7:0] card1Ctrl;
	logic [1:0] ctrlStrobe;
	logic emergencyDeact;
	logic [31:0] seed = 32'h301F;
	logic [8:0] strobeQ[$];
	logic [8:0] expStrobe;
	int nMismatch = 0;
	int testsRun = 0;
	int cycles = 0;
	// ==========================================
	// Clock, instances
	always #50 clk = ~clk;
	dcisp_bus_if bus();
	dcisp_master dcisp_master_inst (.clk(clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest), .bus(bus));
	dcisp_slave #(.SUP_DELAY(16'h0008)) dcisp_slave_inst (.clk(clk), .resetn(resetn), .addrStrapLow(1'b0),
		.addrStrapHigh(1'b1), .supplyOk(supplyOk), .cardPresent(cardPresent), .cardIoLevel(cardIoLevel),
		.cardActive(cardActive), .muteEvent(muteEvent), .earlyEvent(earlyEvent), .protEvent(protEvent),
		.card0Ctrl(card0Ctrl), .card1Ctrl(card1Ctrl), .ctrlStrobe(ctrlStrobe),
		.emergencyDeact(emergencyDeact), .bus(bus));
	dcisp_chk #(.STRAPS(2'h2)) dcisp_chk_inst (.clk(clk), .resetn(resetn), .scl(bus.scl), .sda(bus.sda),
		.sclOut(bus.sclOut), .sdaOut(bus.sdaOut), .irqOut(bus.irqOut), .sdaSlaveOe_n(bus.sdaSlaveOe_n));
	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		testsRun++;
		if (g !== e) begin
			nMismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic endOfTest();
		if (nMismatch == 0 && testsRun > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Avalon access, held until waitrequest sampled low
	task automatic avs(input logic w, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= w;
		avsRead <= ~w;
		@(posedge clk);
		while (avsWaitrequest !== 1'b0) @(posedge clk);
		q = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	// One bus frame, polled until not busy
	task automatic xfer(input logic [7:0] ad, input logic [7:0] dat, output logic [31:0] st);
		avs(1'b1, CMD_ADDR, {15'h0, 1'b1, dat, ad}, st);
		do avs(1'b0, STAT_ADDR, 32'h0, st); while (st[1] !== 1'b0);
	endtask
	// Timeout and control strobe monitor
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			nMismatch++;
			endOfTest();
		end
		if (ctrlStrobe !== 2'h0) begin
			expStrobe = (strobeQ.size() > 0) ? strobeQ.pop_front() : 9'h1FF;
			chk("control byte", expStrobe, {ctrlStrobe[1], ctrlStrobe[1] ? card1Ctrl : card0Ctrl});
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] st;
		logic [7:0] adr [5] = '{8'h44, 8'h4C, 8'h40, 8'h42, 8'h46};
		logic [7:0] ev [2] = '{8'h20, 8'h50};
		logic [7:0] base;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk("irq in supervision", 32'h0, bus.irq_n);
		chk("deactivation in supervision", 32'h1, emergencyDeact);
		repeat (30) @(negedge clk);
		chk("deactivation after supervision", 32'h0, emergencyDeact);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			if (i < 2) strobeQ.push_back({i[0], seed[7:0]});
			xfer(adr[i], seed[7:0], st);
			chk("write nack", i >= 2, st[2]);
		end
		for (int k = 0; k < 4; k++) begin
			if (k == 2) begin
				@(posedge clk);
				muteEvent <= 2'h1;
				earlyEvent <= 2'h2;
				protEvent <= 2'h2;
				@(posedge clk);
				muteEvent <= 2'h0;
				earlyEvent <= 2'h0;
				protEvent <= 2'h0;
				repeat (4) @(negedge clk);
				chk("irq on event", 32'h0, bus.irq_n);
			end
			@(posedge clk);
			seed = lfsr(seed);
			cardIoLevel <= seed[1:0];
			cardActive <= seed[3:2];
			xfer({4'h4, k[0], 3'h5}, 8'h00, st);
			base = {seed[2 + k[0]], 4'h0, seed[k[0]], 1'b0, cardPresent[k[0]]};
			if (k < 2) chk("first status", base | 8'h08, st[15:8] & 8'hFD);
			else chk("event status", base | ev[k[0]], st[15:8]);
			chk("read nack", 32'h0, st[2]);
			@(negedge clk);
			if (k[0]) chk("irq after reads", 32'h1, bus.irq_n);
		end
		@(posedge clk);
		supplyOk <= 1'b0;
		repeat (20) @(negedge clk);
		chk("deactivation on drop", 32'h1, emergencyDeact);
		chk("irq on drop", 32'h0, bus.irq_n);
		chk("pending strobes", 32'h0, strobeQ.size());
		endOfTest();
	end
endmodule
